/* File: logic/sac_top.sv */
// Channel select, test select and successive-approximation sequencer of a
// 10-bit converter, with an APB register slave.
// Assumes a comparator and resistor tap selector outside, and that pclk is
// the peripheral clock at 20 MHz.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"

module sac_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       cmp_at_or_above,
    output logic [`SAC_CODE_HI:0]           analog_channel_code,
    output logic                            analog_channel_valid,
    output logic                            int_ref_route,
    output logic                            ground_route,
    output logic                            sample_hold,
    output logic [`SAC_APPROX_W-1:0]        tap_code,
    output logic                            conversion_done_irq,
    output logic                            conversion_busy
);

    sac_pkg::sac_state_t r;
    sac_pkg::sac_state_t n;

    logic                        fad_tick;
    logic                        busy;
    logic                        rd_setup;
    logic                        wr_acc;
    logic                        mode_wr;
    logic                        result_read;
    logic                        hit_any;
    logic                        hit_ro;
    logic [3:0]                  samp_last;
    logic [`SAC_APPROX_W-1:0]    resolved;
    logic [31:0]                 rd_mux;

    // ------------------------------------------------------------------------
    // Helper functions.
    // ------------------------------------------------------------------------
    // True when the address is the byte address of a register index.
    function automatic logic sac_hit(input logic [31:0] a, input logic [19:0] idx);
        sac_hit = (a == {10'h000, idx, 2'b00});
    endfunction : sac_hit

    function automatic logic [`SAC_APPROX_W-1:0] sac_mask(input logic [3:0] b);
        sac_mask = `SAC_APPROX_W'(1) << b;
    endfunction : sac_mask

    // Pins zero to ten and the internal reference are the only legal codes.
    function automatic logic sac_code_legal(input logic [`SAC_CODE_HI:0] c);
        sac_code_legal = (c <= `SAC_CODE_LAST_PIN) || (c == `SAC_CODE_INT_REF);
    endfunction : sac_code_legal

    // ------------------------------------------------------------------------
    // Conversion clock.
    // ------------------------------------------------------------------------
    assign busy = (r.fsm != sac_pkg::SAC_IDLE);

    // The divider runs only while busy, so a conversion started from standby begins on a
    // fresh conversion-clock period; a restart from the load state keeps the divider count.
    // Conversion-clock pacing.
    sac_fad_timer i_sac_fad_timer (
        .pclk    (pclk),
        .presetn (presetn),
        .enable  (busy),
        .fr      (r.fr),
        .tick    (fad_tick)
    );

    // ------------------------------------------------------------------------
    // Bus decode.
    // ------------------------------------------------------------------------
    // Read data is captured in the setup cycle, so it already stands in the
    // register when the access cycle completes.
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_acc   = psel && penable && pwrite;
    assign mode_wr  = wr_acc && sac_hit(paddr, `SAC_IDX_MODE);

    assign hit_ro = sac_hit(paddr, `SAC_IDX_RWORD) || sac_hit(paddr, `SAC_IDX_RBYTE);
    assign hit_any = hit_ro
                  || sac_hit(paddr, `SAC_IDX_MODE)
                  || sac_hit(paddr, `SAC_IDX_CHAN)
                  || sac_hit(paddr, `SAC_IDX_TEST);

    // A read of either result register holds off a pending result load.
    assign result_read = psel && !pwrite && hit_ro;

    // No wait states; unmapped addresses and writes to the result registers
    // answer with an error and change nothing.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!hit_any || (pwrite && hit_ro));
    assign prdata  = r.prdata;

    // ------------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------------
    always_comb begin
        rd_mux = `SAC_RST_DATA;
        if (sac_hit(paddr, `SAC_IDX_MODE)) begin
            rd_mux[`SAC_RUN_BIT]            = r.run;
            rd_mux[`SAC_FR_HI:`SAC_FR_LO]   = r.fr;
            rd_mux[`SAC_LV_BIT]             = r.lv;
            rd_mux[`SAC_PWR_BIT]            = r.pwr;
        end else if (sac_hit(paddr, `SAC_IDX_CHAN)) begin
            rd_mux[`SAC_CODE_HI:0]          = r.code;
        end else if (sac_hit(paddr, `SAC_IDX_TEST)) begin
            rd_mux[`SAC_GND_BIT]            = r.gnd;
        end else if (sac_hit(paddr, `SAC_IDX_RWORD)) begin
            rd_mux[15:0]                    = {r.result, `SAC_RES_PAD};
        end else if (sac_hit(paddr, `SAC_IDX_RBYTE)) begin
            rd_mux[7:0]                     = r.result[`SAC_APPROX_W-1:2];
        end
    end

    // ------------------------------------------------------------------------
    // Sampling length and the compare outcome of the bit under trial.
    // ------------------------------------------------------------------------
    assign samp_last = (r.lv ? `SAC_SAMP_LV1 : `SAC_SAMP_LV0) - 4'h1;

    // Keep trial bit only when input is not below the tap.
    assign resolved = cmp_at_or_above ? r.approx : (r.approx & ~sac_mask(r.bit_idx));

    // ------------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------------
    // Register writes come first, so the sequencer below sees the run bit of
    // a write in the same cycle: a start or an abort takes one edge.
    always_comb begin
        n     = r;
        n.irq = 1'b0;

        if (rd_setup) begin
            n.prdata = rd_mux;
        end

        if (wr_acc && sac_hit(paddr, `SAC_IDX_CHAN)) begin
            n.code = pwdata[`SAC_CODE_HI:0];
        end
        if (wr_acc && sac_hit(paddr, `SAC_IDX_TEST)) begin
            n.gnd = pwdata[`SAC_GND_BIT];
        end
        if (mode_wr) begin
            n.pwr = pwdata[`SAC_PWR_BIT];
            n.lv  = pwdata[`SAC_LV_BIT];
            n.fr  = pwdata[`SAC_FR_HI:`SAC_FR_LO];
            // Run needs power in the same write.
            n.run = pwdata[`SAC_RUN_BIT] && pwdata[`SAC_PWR_BIT];
        end

        case (r.fsm)
            sac_pkg::SAC_IDLE: begin
                if (n.run) begin
                    n.fsm = sac_pkg::SAC_SAMPLE;
                    n.cnt = 4'h0;
                end
            end
            sac_pkg::SAC_SAMPLE: begin
                if (!n.run) begin
                    n.fsm = sac_pkg::SAC_IDLE;
                end else if (fad_tick) begin
                    if (r.cnt == samp_last) begin
                        n.fsm     = sac_pkg::SAC_CONV;
                        n.bit_idx = `SAC_APPROX_MSB;
                        // First trial is the half-supply tap.
                        n.approx  = sac_mask(`SAC_APPROX_MSB);
                    end else begin
                        n.cnt = r.cnt + 4'h1;
                    end
                end
            end
            sac_pkg::SAC_CONV: begin
                if (!n.run) begin
                    n.fsm = sac_pkg::SAC_IDLE;
                end else if (fad_tick) begin
                    if (r.bit_idx == 4'h0) begin
                        n.approx = resolved;
                        n.fsm    = sac_pkg::SAC_FINISH;
                        n.cnt    = 4'h0;
                    end else begin
                        // Next trial bit on the resolved value picks the tap.
                        n.approx  = resolved | sac_mask(r.bit_idx - 4'h1);
                        n.bit_idx = r.bit_idx - 4'h1;
                    end
                end
            end
            sac_pkg::SAC_FINISH: begin
                // The closing cycles keep the hold up until the load.
                if (!n.run) begin
                    n.fsm = sac_pkg::SAC_IDLE;
                end else if (fad_tick) begin
                    if (r.cnt == `SAC_FINISH_CYC - 4'h1) begin
                        n.fsm = sac_pkg::SAC_LOAD;
                    end else begin
                        n.cnt = r.cnt + 4'h1;
                    end
                end
            end
            sac_pkg::SAC_LOAD: begin
                if (mode_wr) begin
                    // Mode write wins; nothing stored, no interrupt.
                    // A write that sets run again starts a fresh sample.
                    n.fsm = n.run ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
                    n.cnt = 4'h0;
                end else if (!result_read) begin
                    // Load waits while a result read is on the bus.
                    n.result = r.approx;
                    n.irq    = 1'b1;
                    n.run    = 1'b0;
                    n.fsm    = sac_pkg::SAC_IDLE;
                end
            end
            default: begin
                // A corrupt state code falls back to standby.
                n.fsm = sac_pkg::SAC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State register.
    // ------------------------------------------------------------------------
    // The reset branch loads constants only; afterwards the copy loads each edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.run     <= 1'b0;
            r.pwr     <= 1'b0;
            r.lv      <= 1'b0;
            r.fr      <= 2'h0;
            r.code    <= '0;
            r.gnd     <= 1'b0;
            r.fsm     <= sac_pkg::SAC_IDLE;
            r.cnt     <= 4'h0;
            r.bit_idx <= 4'h0;
            r.approx  <= `SAC_RST_APPROX;
            r.result  <= `SAC_RST_APPROX;
            r.irq     <= 1'b0;
            r.prdata  <= `SAC_RST_DATA;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------------
    // Analog side.
    // ------------------------------------------------------------------------
    // A prohibited code still converts, but routes no pin to the converter.
    // Code decode; prohibited codes select nothing.
    assign analog_channel_code  = r.code;
    assign analog_channel_valid = sac_code_legal(r.code) && !r.gnd;
    // Ground select overrides the channel code.
    assign int_ref_route        = (r.code == `SAC_CODE_INT_REF) && !r.gnd;
    assign ground_route         = r.gnd;
    // Hold from the first compare until standby or a restart from the load state.
    assign sample_hold          = busy && (r.fsm != sac_pkg::SAC_SAMPLE);
    assign tap_code             = r.approx;
    assign conversion_done_irq  = r.irq;
    assign conversion_busy      = busy;

endmodule : sac_top
`default_nettype wire

/* File: common/sac_consts.svh */
// Constants of the converter channel select and approximation sequencer.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------------
`define SAC_IDX_TEST        20'hF0013
`define SAC_IDX_CHAN        20'hFFF31
`define SAC_IDX_MODE        20'hFFF30
`define SAC_IDX_RWORD       20'hFFF1E
`define SAC_IDX_RBYTE       20'hFFF1F

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define SAC_RUN_BIT         7
`define SAC_FR_HI           4
`define SAC_FR_LO           3
`define SAC_LV_BIT          2
`define SAC_PWR_BIT         0
`define SAC_GND_BIT         1
`define SAC_CODE_HI         3

// ----------------------------------------------------------------------------
// Codes, widths and reset values.
// ----------------------------------------------------------------------------
`define SAC_CODE_LAST_PIN   4'hA
`define SAC_CODE_INT_REF    4'hD
`define SAC_APPROX_W        10
`define SAC_APPROX_MSB      4'h9
`define SAC_RES_PAD         6'h00
`define SAC_RST_REG8        8'h00
`define SAC_RST_WORD        16'h0000
`define SAC_RST_APPROX      10'h000
`define SAC_RST_DATA        32'h0000_0000

// ----------------------------------------------------------------------------
// Timing in conversion-clock cycles; divider last counts in peripheral clocks.
// ----------------------------------------------------------------------------
`define SAC_SAMP_LV0        4'h9
`define SAC_SAMP_LV1        4'h3
`define SAC_FINISH_CYC      4'h2
`define SAC_DIV_FR0         3'h7
`define SAC_DIV_FR1         3'h3
`define SAC_DIV_FR2         3'h1
`define SAC_DIV_FR3         3'h0

`endif

/* File: common/sac_pkg.sv */
// Types of the converter channel select and approximation sequencer.
// Assumes the constants header is on the include path.
`default_nettype none
`include "sac_consts.svh"

package sac_pkg;

    // ------------------------------------------------------------------------
    // Sequencer states, one-hot.
    // ------------------------------------------------------------------------
    typedef enum logic [4:0] {
        SAC_IDLE   = 5'h01,
        SAC_SAMPLE = 5'h02,
        SAC_CONV   = 5'h04,
        SAC_FINISH = 5'h08,
        SAC_LOAD   = 5'h10
    } sac_fsm_t;

    // ------------------------------------------------------------------------
    // Whole state of the top module.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic                        run;
        logic                        pwr;
        logic                        lv;
        logic [1:0]                  fr;
        logic [`SAC_CODE_HI:0]       code;
        logic                        gnd;
        sac_fsm_t                    fsm;
        logic [3:0]                  cnt;
        logic [3:0]                  bit_idx;
        logic [`SAC_APPROX_W-1:0]    approx;
        logic [`SAC_APPROX_W-1:0]    result;
        logic                        irq;
        logic [31:0]                 prdata;
    } sac_state_t;

    // ------------------------------------------------------------------------
    // State of the conversion-clock divider.
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]                  cnt;
    } sac_tmr_t;

endpackage : sac_pkg
`default_nettype wire

/* File: logic/sac_fad_timer.sv */
// Conversion-clock divider: gives one tick per conversion-clock period.
// Assumes the enable stays high for the whole conversion and drops in standby.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"

module sac_fad_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        enable,
    input  wire logic [1:0]  fr,
    output logic             tick
);

    sac_pkg::sac_tmr_t r;
    sac_pkg::sac_tmr_t n;
    logic [2:0]        last;

    // ------------------------------------------------------------------------
    // Divide ratio: 8, 4, 2 or 1 peripheral clocks per conversion clock.
    // ------------------------------------------------------------------------
    always_comb begin
        case (fr)
            2'h0:    last = `SAC_DIV_FR0;
            2'h1:    last = `SAC_DIV_FR1;
            2'h2:    last = `SAC_DIV_FR2;
            default: last = `SAC_DIV_FR3;
        endcase
    end

    assign tick = enable && (r.cnt == last);

    always_comb begin
        n = r;
        if (!enable || tick) begin
            n.cnt = 3'h0;
        end else begin
            n.cnt = r.cnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule : sac_fad_timer
`default_nettype wire

/* File: tb/sac_cmp_model.sv */
// Far-side model: sample-and-hold and comparator against the tap code.
// Assumes the bench drives the analog input as a 10-bit code in level.
`timescale 1ns/1ps
`default_nettype none

module sac_cmp_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       sample_hold,
    input  wire logic       ground_route,
    input  wire logic [9:0] level,
    input  wire logic [9:0] tap_code,
    output logic            cmp_at_or_above
);
    logic [9:0] held_r;
    logic       flip_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_r <= 10'h000;
            flip_r <= 1'b0;
        end else begin
            flip_r <= ~flip_r;
            if (!sample_hold) begin
                held_r <= ground_route ? 10'h000 : level;
            end
        end
    end

    // Compare against tap.
    // The ladder, never the internal reference, is the comparator threshold.
    // Outside hold the output toggles, so a sequencer that compares early sees noise.
    assign cmp_at_or_above = sample_hold ? (held_r >= tap_code) : flip_r;
endmodule : sac_cmp_model
`default_nettype wire

/* File: tb/sac_top_sva.sv */
// Checker of the converter sequencer, bound to the ports of its top module.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"

module sac_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cmp_at_or_above,
    input wire logic [3:0]  analog_channel_code,
    input wire logic        analog_channel_valid,
    input wire logic        int_ref_route,
    input wire logic        ground_route,
    input wire logic        sample_hold,
    input wire logic [9:0]  tap_code,
    input wire logic        conversion_done_irq,
    input wire logic        conversion_busy
);
    localparam logic [31:0] MODE_A = {10'h000, `SAC_IDX_MODE, 2'b00};
    logic mode_wr;
    assign mode_wr = psel && penable && pwrite && (paddr == MODE_A);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------------
    a_ref_code: assert property (int_ref_route |->
        analog_channel_code == `SAC_CODE_INT_REF)
        else $error("reference route with wrong code");
    a_valid_code: assert property (analog_channel_valid |->
        (analog_channel_code <= `SAC_CODE_LAST_PIN || analog_channel_code == `SAC_CODE_INT_REF))
        else $error("prohibited code marked valid");
    a_ground_only: assert property (ground_route |->
        !analog_channel_valid && !int_ref_route)
        else $error("channel routed while ground selected");
    a_hold_msb: assert property ($rose(sample_hold) |-> tap_code == 10'h200)
        else $error("first trial is not the half tap");
    a_hold_busy: assert property (sample_hold |-> conversion_busy && $past(conversion_busy))
        else $error("hold without a sampling cycle first");
    a_done_cause: assert property (conversion_done_irq |-> $past(sample_hold))
        else $error("done without a held conversion");
    a_done_pulse: assert property (conversion_done_irq |->
        !conversion_busy ##1 !conversion_done_irq)
        else $error("done is not a single pulse into standby");
    a_conv_bound: assert property ($rose(conversion_busy) |-> ##[1:200] !conversion_busy)
        else $error("conversion does not end");
    a_run_start: assert property (mode_wr && pwdata[7] && pwdata[0] &&
        !conversion_busy |=> conversion_busy)
        else $error("run write did not start");
    a_run_off: assert property (mode_wr && pwdata[7] && !pwdata[0] &&
        !conversion_busy |=> !conversion_busy)
        else $error("run with power off started");
    a_abort_idle: assert property (mode_wr && !pwdata[7] && conversion_busy |=>
        !conversion_busy && !conversion_done_irq)
        else $error("abort did not return to standby");

    c_done: cover property (conversion_done_irq);
    c_abort: cover property (mode_wr && !pwdata[7] && conversion_busy);
    c_refused: cover property (mode_wr && pwdata[7] && !pwdata[0]);
endmodule : sac_top_chk

bind sac_top sac_top_chk i_sac_top_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_at_or_above(cmp_at_or_above),
    .analog_channel_code(analog_channel_code), .analog_channel_valid(analog_channel_valid),
    .int_ref_route(int_ref_route), .ground_route(ground_route), .sample_hold(sample_hold),
    .tap_code(tap_code), .conversion_done_irq(conversion_done_irq),
    .conversion_busy(conversion_busy));
`default_nettype wire

/* File: tb/sac_top_tb.sv */
// Testbench of the converter sequencer: APB register tests and conversions.
// Assumes the comparator model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "sac_consts.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module sac_top_tb;
    localparam logic [31:0] A_TEST = {10'h000, `SAC_IDX_TEST, 2'b00};
    localparam logic [31:0] A_CHAN = {10'h000, `SAC_IDX_CHAN, 2'b00};
    localparam logic [31:0] A_MODE = {10'h000, `SAC_IDX_MODE, 2'b00};
    localparam logic [31:0] A_WORD = {10'h000, `SAC_IDX_RWORD, 2'b00};
    localparam logic [31:0] A_BYTE = {10'h000, `SAC_IDX_RBYTE, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        cmp_at_or_above, analog_channel_valid, int_ref_route, ground_route;
    logic        sample_hold, conversion_done_irq, conversion_busy;
    logic [3:0]  analog_channel_code;
    logic [9:0]  tap_code, level;
    int          err_total, checks, i, n;
    logic [7:0]  md [5] = '{8'h9D, 8'h99, 8'h81, 8'h8D, 8'h95};
    logic [9:0]  lv [5] = '{10'h3FF, 10'h000, 10'h200, 10'h1FF, 10'h155};
    logic [31:0] ra [4] = '{A_WORD, A_BYTE, A_TEST, A_CHAN};

    sac_top i_sac_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_at_or_above(cmp_at_or_above),
        .analog_channel_code(analog_channel_code), .analog_channel_valid(analog_channel_valid),
        .int_ref_route(int_ref_route), .ground_route(ground_route), .sample_hold(sample_hold),
        .tap_code(tap_code), .conversion_done_irq(conversion_done_irq),
        .conversion_busy(conversion_busy));
    sac_cmp_model i_sac_cmp_model (.pclk(pclk), .presetn(presetn), .sample_hold(sample_hold),
        .ground_route(ground_route), .level(level), .tap_code(tap_code),
        .cmp_at_or_above(cmp_at_or_above));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ------------------------------------------------------------------------
    // Bus and conversion tasks.
    // ------------------------------------------------------------------------
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 100) begin
            k++;
            @(posedge pclk);
        end
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task conv(input logic [7:0] m, input logic [9:0] e);
        int k;
        apb(1'b1, A_MODE, {24'h000000, m});
        k = 0;
        while (conversion_done_irq !== 1'b1 && k < 400) begin
            k++;
            @(posedge pclk);
        end
        `CHK("done", 1'b1, conversion_done_irq)
        apb(1'b0, A_WORD, 32'h0);
        `CHK("word", {16'h0000, e, 6'h00}, rd)
        apb(1'b0, A_BYTE, 32'h0);
        `CHK("byte", {24'h000000, e[9:2]}, rd)
        apb(1'b0, A_MODE, 32'h0);
        `CHK("run", 1'b0, rd[7])
        `CHK("mode", {24'h000000, m & 8'h7F}, rd)
    endtask : conv

    task summarize;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    initial begin
        #(50 * 20000);
        err_total++;
        $display("Error watchdog expected end seen timeout");
        summarize;
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, level} = '0;
        err_total = 0;
        checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, ra[i], 32'h0);
            `CHK("reset value", 32'h00000000, rd)
            `CHK("no error", 1'b0, serr)
        end
        apb(1'b0, 32'h00000000, 32'h0);
        `CHK("unmapped error", 1'b1, serr)
        apb(1'b1, A_WORD, 32'h0000FFFF);
        `CHK("read-only error", 1'b1, serr)
        $display("test registers done");
        for (i = 0; i < 16; i++) begin
            apb(1'b1, A_CHAN, {28'h0, i[3:0]});
            apb(1'b0, A_CHAN, 32'h0);
            `CHK("chan", {28'h0, i[3:0]}, rd)
            `CHK("code", i[3:0], analog_channel_code)
            `CHK("valid", 1'(i <= 10 || i == 13), analog_channel_valid)
            `CHK("ref", 1'(i == 13), int_ref_route)
        end
        $display("test channels done");
        apb(1'b1, A_CHAN, 32'h3);
        for (i = 0; i < 5; i++) begin
            level <= lv[i];
            conv(md[i], lv[i]);
        end
        $display("test conversions done");
        apb(1'b1, A_TEST, 32'h2);
        `CHK("ground", 1'b1, ground_route)
        `CHK("ground valid", 1'b0, analog_channel_valid)
        level <= 10'h2AA;
        conv(8'h9D, 10'h000);
        apb(1'b1, A_TEST, 32'h0);
        apb(1'b1, A_CHAN, 32'hD);
        `CHK("ref on", 1'b1, int_ref_route)
        level <= 10'h123;
        conv(8'h99, 10'h123);
        $display("test reference done");
        apb(1'b1, A_MODE, 32'h80);
        `CHK("refused", 1'b0, conversion_busy)
        level <= 10'h0F0;
        apb(1'b1, A_MODE, 32'h81);
        `CHK("started", 1'b1, conversion_busy)
        repeat (100) @(posedge pclk);
        apb(1'b1, A_MODE, 32'h01);
        `CHK("aborted", 1'b0, conversion_busy)
        n = 0;
        repeat (200) begin
            @(posedge pclk);
            if (conversion_done_irq === 1'b1) n++;
        end
        `CHK("late done", 0, n)
        apb(1'b0, A_WORD, 32'h0);
        `CHK("kept word", {16'h0000, 10'h123, 6'h00}, rd)
        $display("test abort done");
        summarize;
    end
endmodule : sac_top_tb
`default_nettype wire
